// file: logic/rtc_calendar_alarm_control.sv
// Operation
// - calendar runs only while run enable is 1; its write needs unlock already set
// - time window writes are accepted only while the write unlock bit is 1
// - rollover flag marks ripple time; software reads twice and compares
// - half second status is 1 in the second half of each second
// - writing the minute/second low byte clears the half second status
// - clock pin is driven only while the output enable bit is 1
// - time pointer 00..11 selects min/sec, weekday/hour, month/day, zero/year
// - time pointer decrements on each high byte access, holding at 00
// - signed trim, each unit adds or removes 4 pulses per minute
// - configuration register is cleared only by power-on reset
// - pin select 00 alarm toggle, 01 seconds clock, 10 raw source
// - alarm enable clears after an event when repeat is 0 and chime off
// - with chime the repeat count wraps 00h to FFh, else stops at 00h
// - interval codes 0..9 pick half second up to year; others reserved
// - a yearly alarm on 29 February fires only in leap years
// - alarm pointer selects min/sec, weekday/hour, month/day, unimplemented
// - alarm pointer decrements on each high byte access, holding at 00
// - repeat count gives further alarms and decrements on each event
// - year holds two BCD digits in the low byte, upper byte zero
// - year register writes are accepted only while unlocked
// - unimplemented bits read zero and ignore writes
// - unlock is set only right after key writes 55h then AAh
// - any read of a window decrements its pointer, full word reads
// - fuse 1 selects the crystal source, 0 the low power RC source
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_calendar_alarm_control (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire rtc_pkg::axi_req_t s_axi_req,
  output var  rtc_pkg::axi_rsp_t s_axi_rsp,
  input  wire logic              secondary_crystal_osc,
  input  wire logic              low_power_rc_osc,
  input  wire logic              clock_source_fuse,
  output logic                   clock_pin_out,
  output logic                   clock_pin_oe_n
);
  rtc_pkg::state_t s_r;
  rtc_pkg::state_t s_nxt;
  logic            src_lvl;
  logic            src_rise;
  logic [1:0]      inc;
  logic [15:0]     psum;
  logic            half_sec;
  logic            roll_flag;
  logic            wr_go;
  logic            awready;
  logic            wready;
  logic            arready;
  logic            alarm_hit;
  logic            alarm_event;
  logic            m_s, m_m, m_h, m_w, m_d, m_o;
  logic [15:0]     rd;
  logic            rd_ok;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    unique case (m)
      8'h02:                      last_day = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
  endfunction

  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    ptr_dec = (p == 2'h0) ? 2'h0 : p - 2'h1;
  endfunction

  // status seen by software
  assign half_sec  = s_r.presc[14];
  assign roll_flag = s_r.run_en && (s_r.presc >= `ROLL_START);
  // bus handshakes: one write and one read held at a time
  assign wr_go   = s_r.aw_held && s_r.w_held;
  assign awready = !s_r.aw_held && !s_r.bvalid;
  assign wready  = !s_r.w_held && !s_r.bvalid;
  assign arready = !s_r.rvalid && !wr_go;

  assign s_axi_rsp.awready = awready;
  assign s_axi_rsp.wready  = wready;
  assign s_axi_rsp.arready = arready;
  assign s_axi_rsp.bvalid  = s_r.bvalid;
  assign s_axi_rsp.bresp   = s_r.bresp;
  assign s_axi_rsp.rvalid  = s_r.rvalid;
  assign s_axi_rsp.rdata   = {16'h0000, s_r.rdata};
  assign s_axi_rsp.rresp   = s_r.rresp;
  assign clock_pin_out     = s_r.pin_out;
  assign clock_pin_oe_n    = s_r.pin_oe_n;

  // next state of the whole block
  always_comb begin
    s_nxt = s_r;
    // two-stage synchronisers for pins and fuse
    s_nxt.src_meta  = {secondary_crystal_osc, low_power_rc_osc};
    s_nxt.src_sync  = s_r.src_meta;
    s_nxt.fuse_meta = clock_source_fuse;
    s_nxt.fuse_sync = s_r.fuse_meta;
    src_lvl  = s_r.fuse_sync ? s_r.src_sync[1] : s_r.src_sync[0];
    src_rise = src_lvl && !s_r.src_prev;
    s_nxt.src_prev = src_lvl;
    // prescaler with per-minute drift trim
    s_nxt.sec_pulse  = 1'b0;
    s_nxt.half_pulse = 1'b0;
    inc  = 2'h1;
    psum = {1'b0, s_r.presc};
    if (s_r.run_en && src_rise) begin
      if (s_r.adj == 11'h000) begin
        inc = 2'h1;
      end else if (!s_r.adj[10]) begin
        inc = 2'h2;
        s_nxt.adj = s_r.adj - 11'h001;
      end else begin
        inc = 2'h0;
        s_nxt.adj = s_r.adj + 11'h001;
      end
      psum = {1'b0, s_r.presc} + {14'h0000, inc};
      s_nxt.presc = psum[14:0];
      if (psum[15]) begin
        s_nxt.sec_pulse  = 1'b1;
        s_nxt.half_pulse = 1'b1;
        // BCD calendar ripple
        if (s_r.sec == 8'h59) begin
          s_nxt.sec = 8'h00;
          s_nxt.adj = {s_r.cal[7], s_r.cal, {`CAL_SHIFT{1'b0}}};
          if (s_r.min == 8'h59) begin
            s_nxt.min = 8'h00;
            if (s_r.hr == 8'h23) begin
              s_nxt.hr   = 8'h00;
              s_nxt.wday = (s_r.wday == 8'h06) ? 8'h00 : s_r.wday + 8'h01;
              if (s_r.day == last_day(s_r.mon, s_r.yr)) begin
                s_nxt.day = 8'h01;
                if (s_r.mon == 8'h12) begin
                  s_nxt.mon = 8'h01;
                  s_nxt.yr  = (s_r.yr == 8'h99) ? 8'h00 : bcd_inc(s_r.yr);
                end else begin
                  s_nxt.mon = bcd_inc(s_r.mon);
                end
              end else begin
                s_nxt.day = bcd_inc(s_r.day);
              end
            end else begin
              s_nxt.hr = bcd_inc(s_r.hr);
            end
          end else begin
            s_nxt.min = bcd_inc(s_r.min);
          end
        end else begin
          s_nxt.sec = bcd_inc(s_r.sec);
        end
      end else if (!s_r.presc[14] && psum[14]) begin
        s_nxt.half_pulse = 1'b1;
      end
    end
    // alarm compare, one cycle after the time has settled
    m_s = (s_r.sec == s_r.asec);
    m_m = (s_r.min == s_r.amin);
    m_h = (s_r.hr == s_r.ahr);
    m_w = (s_r.wday == s_r.awday);
    m_d = (s_r.day == s_r.aday);
    m_o = (s_r.mon == s_r.amon);
    unique case (s_r.interval)
      4'h0:    alarm_hit = s_r.half_pulse;
      4'h1:    alarm_hit = s_r.sec_pulse;
      4'h2:    alarm_hit = s_r.sec_pulse && (s_r.sec[3:0] == s_r.asec[3:0]);
      4'h3:    alarm_hit = s_r.sec_pulse && m_s;
      4'h4:    alarm_hit = s_r.sec_pulse && m_s && (s_r.min[3:0] == s_r.amin[3:0]);
      4'h5:    alarm_hit = s_r.sec_pulse && m_s && m_m;
      4'h6:    alarm_hit = s_r.sec_pulse && m_s && m_m && m_h;
      4'h7:    alarm_hit = s_r.sec_pulse && m_s && m_m && m_h && m_w;
      4'h8:    alarm_hit = s_r.sec_pulse && m_s && m_m && m_h && m_d;
      // 29 February only exists in leap years, so it matches only then
      4'h9:    alarm_hit = s_r.sec_pulse && m_s && m_m && m_h && m_d && m_o;
      default: alarm_hit = 1'b0;
    endcase
    alarm_event = s_r.alarm_en && alarm_hit;
    if (alarm_event) begin
      s_nxt.alarm_tgl = !s_r.alarm_tgl;
      if (s_r.repeat_cnt != 8'h00)
        s_nxt.repeat_cnt = s_r.repeat_cnt - 8'h01;
      else if (s_r.chime)
        s_nxt.repeat_cnt = 8'hFF;
      else
        s_nxt.alarm_en = 1'b0;
    end
    // clock pin, enable gates every selection
    unique case (s_r.sel)
      2'h0:    s_nxt.pin_out = s_r.alarm_tgl;
      2'h1:    s_nxt.pin_out = s_r.presc[14];
      2'h2:    s_nxt.pin_out = src_lvl;
      default: s_nxt.pin_out = 1'b0;
    endcase
    s_nxt.pin_oe_n = !s_r.oe;
    // write address and data capture, either order
    if (s_axi_req.awvalid && awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = s_axi_req.awaddr[7:0];
    end
    if (s_axi_req.wvalid && wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_req.wdata[15:0];
      s_nxt.wstrb  = s_axi_req.wstrb[1:0];
    end
    if (s_r.bvalid && s_axi_req.bready)
      s_nxt.bvalid = 1'b0;
    // register write, software wins over hardware in the same cycle
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `RESP_OKAY;
      s_nxt.key     = rtc_pkg::KEY_IDLE;
      unique case (s_r.awaddr)
        `OFS_CFG: begin
          if (s_r.wstrb[1]) begin
            s_nxt.unlock = s_r.wdata[`BIT_UNLOCK] &&
                           (s_r.unlock || (s_r.key == rtc_pkg::KEY_ARMED));
            if (s_r.unlock)
              s_nxt.run_en = s_r.wdata[`BIT_RUN];
            s_nxt.oe   = s_r.wdata[`BIT_OE];
            s_nxt.tptr = s_r.wdata[9:8];
          end
          if (s_r.wstrb[0])
            s_nxt.cal = s_r.wdata[7:0];
        end
        `OFS_PAD: begin
          if (s_r.wstrb[0])
            s_nxt.sel = s_r.wdata[2:1];
        end
        `OFS_ALARM: begin
          if (s_r.wstrb[1]) begin
            s_nxt.alarm_en = s_r.wdata[`BIT_AEN];
            s_nxt.chime    = s_r.wdata[`BIT_CHIME];
            s_nxt.interval = s_r.wdata[13:10];
            s_nxt.aptr     = s_r.wdata[9:8];
          end
          if (s_r.wstrb[0])
            s_nxt.repeat_cnt = s_r.wdata[7:0];
        end
        `OFS_YEAR: begin
          if (s_r.wstrb[0] && s_r.unlock)
            s_nxt.yr = s_r.wdata[7:0];
        end
        `OFS_TIME_WIN: begin
          if (s_r.unlock && s_r.wstrb[1]) begin
            unique case (s_r.tptr)
              2'h0:    s_nxt.min  = s_r.wdata[15:8] & `MASK_SEC;
              2'h1:    s_nxt.wday = s_r.wdata[15:8] & `MASK_WDAY;
              2'h2:    s_nxt.mon  = s_r.wdata[15:8] & `MASK_MON;
              default: s_nxt.min  = s_nxt.min;
            endcase
          end
          if (s_r.unlock && s_r.wstrb[0]) begin
            unique case (s_r.tptr)
              2'h0: begin
                s_nxt.sec   = s_r.wdata[7:0] & `MASK_SEC;
                s_nxt.presc = 15'h0000;
                s_nxt.half_pulse = s_nxt.sec_pulse;  // a half tick is void once the phase restarts
              end
              2'h1:    s_nxt.hr  = s_r.wdata[7:0] & `MASK_HR;
              2'h2:    s_nxt.day = s_r.wdata[7:0] & `MASK_DAY;
              default: s_nxt.yr  = s_r.wdata[7:0];
            endcase
          end
          if (s_r.wstrb[1])
            s_nxt.tptr = ptr_dec(s_r.tptr);
        end
        `OFS_ALARM_WIN: begin
          if (s_r.wstrb[1]) begin
            unique case (s_r.aptr)
              2'h0:    s_nxt.amin  = s_r.wdata[15:8] & `MASK_SEC;
              2'h1:    s_nxt.awday = s_r.wdata[15:8] & `MASK_WDAY;
              2'h2:    s_nxt.amon  = s_r.wdata[15:8] & `MASK_MON;
              default: s_nxt.amin  = s_nxt.amin;
            endcase
            s_nxt.aptr = ptr_dec(s_r.aptr);
          end
          if (s_r.wstrb[0]) begin
            unique case (s_r.aptr)
              2'h0:    s_nxt.asec = s_r.wdata[7:0] & `MASK_SEC;
              2'h1:    s_nxt.ahr  = s_r.wdata[7:0] & `MASK_HR;
              2'h2:    s_nxt.aday = s_r.wdata[7:0] & `MASK_DAY;
              default: s_nxt.asec = s_nxt.asec;
            endcase
          end
        end
        `OFS_KEY: begin
          if (s_r.wstrb[0] && s_r.wdata[7:0] == `KEY_FIRST)
            s_nxt.key = rtc_pkg::KEY_GOT_FIRST;
          else if (s_r.wstrb[0] && s_r.wdata[7:0] == `KEY_SECOND &&
                   s_r.key == rtc_pkg::KEY_GOT_FIRST)
            s_nxt.key = rtc_pkg::KEY_ARMED;
        end
        default: s_nxt.bresp = `RESP_SLVERR;
      endcase
    end
    // register read with window pointer side effects
    rd    = 16'h0000;
    rd_ok = 1'b1;
    unique case (s_axi_req.araddr[7:0])
      `OFS_CFG:   rd = {s_r.run_en, 1'b0, s_r.unlock, roll_flag, half_sec,
                        s_r.oe, s_r.tptr, s_r.cal};
      `OFS_PAD:   rd = {13'h0000, s_r.sel, 1'b0};
      `OFS_ALARM: rd = {s_r.alarm_en, s_r.chime, s_r.interval, s_r.aptr,
                        s_r.repeat_cnt};
      `OFS_YEAR:  rd = {8'h00, s_r.yr};
      `OFS_TIME_WIN: begin
        unique case (s_r.tptr)
          2'h0: rd = {s_r.min, s_r.sec};
          2'h1: rd = {s_r.wday, s_r.hr};
          2'h2: rd = {s_r.mon, s_r.day};
          2'h3: rd = {8'h00, s_r.yr};
        endcase
      end
      `OFS_ALARM_WIN: begin
        unique case (s_r.aptr)
          2'h0: rd = {s_r.amin, s_r.asec};
          2'h1: rd = {s_r.awday, s_r.ahr};
          2'h2: rd = {s_r.amon, s_r.aday};
          2'h3: rd = 16'h0000;
        endcase
      end
      `OFS_KEY:   rd = 16'h0000;
      default:    rd_ok = 1'b0;
    endcase
    if (s_axi_req.arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd;
      s_nxt.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (s_axi_req.araddr[7:0] == `OFS_TIME_WIN)
        s_nxt.tptr = ptr_dec(s_r.tptr);
      if (s_axi_req.araddr[7:0] == `OFS_ALARM_WIN)
        s_nxt.aptr = ptr_dec(s_r.aptr);
    end
    if (s_r.rvalid && s_axi_req.rready)
      s_nxt.rvalid = 1'b0;
  end

  // state register, only power-on reset loads it: zero, with day and month 01 and pin_oe_n 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r          <= '0;
      s_r.day      <= `RST_DAY;
      s_r.mon      <= `RST_MON;
      s_r.pin_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_run_lock: assert property (wr_go && s_r.awaddr == `OFS_CFG && !s_r.unlock |=>
    s_r.run_en == $past(s_r.run_en)) else $error("run enable changed while locked");
  a_time_lock: assert property (wr_go && s_r.awaddr == `OFS_TIME_WIN && !s_r.unlock
    && !s_r.run_en |=> $stable(s_r.sec) && $stable(s_r.min) && $stable(s_r.yr))
    else $error("time window written while locked");
  a_roll_before: assert property (s_r.sec_pulse |-> $past(roll_flag))
    else $error("second rollover without ripple flag");
  a_half_phase: assert property (s_r.half_pulse |-> half_sec != s_r.sec_pulse)
    else $error("half second status wrong at half tick");
  a_half_clear: assert property (wr_go && s_r.awaddr == `OFS_TIME_WIN && s_r.unlock
    && s_r.wstrb[0] && s_r.tptr == 2'h0 |=> !half_sec) else $error("half second not cleared");
  a_pin_gate: assert property (!s_r.oe |=> s_r.pin_oe_n)
    else $error("clock pin driven while disabled");
  a_tptr_step: assert property (s_axi_req.arvalid && arready && s_r.tptr != 2'h0 &&
    s_axi_req.araddr[7:0] == `OFS_TIME_WIN |=> s_r.tptr == 2'($past(s_r.tptr) - 2'h1))
    else $error("time pointer did not step down");
  a_alarm_disarm: assert property (alarm_event && s_r.repeat_cnt == 8'h00 && !s_r.chime
    && !wr_go |=> !s_r.alarm_en) else $error("alarm enable not cleared");
  a_chime_wrap: assert property (alarm_event && s_r.repeat_cnt == 8'h00 && s_r.chime
    && !wr_go |=> s_r.repeat_cnt == 8'hFF) else $error("repeat count did not wrap");
  a_repeat_step: assert property (alarm_event && s_r.repeat_cnt != 8'h00 && !wr_go |=>
    s_r.repeat_cnt == 8'($past(s_r.repeat_cnt) - 8'h01)) else $error("repeat count wrong");
  a_year_lock: assert property (wr_go && s_r.awaddr == `OFS_YEAR && !s_r.unlock &&
    !s_r.run_en |=> $stable(s_r.yr)) else $error("year written while locked");

  c_alarm_fire: cover property (alarm_event);
  c_unlock_set: cover property (!s_r.unlock ##1 s_r.unlock);
  c_chime_wrap: cover property (alarm_event && s_r.chime && s_r.repeat_cnt == 8'h00);
  c_minute_roll: cover property (s_r.sec_pulse && s_r.sec == 8'h00);
endmodule
`default_nettype wire

// file: logic/rtc_consts.svh
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
// register byte offsets, low address byte only
`define OFS_CFG        8'h00
`define OFS_PAD        8'h04
`define OFS_ALARM      8'h08
`define OFS_YEAR       8'h0C
`define OFS_TIME_WIN   8'h10
`define OFS_ALARM_WIN  8'h14
`define OFS_KEY        8'h18
// bit positions in calendar_config_calibration and alarm_config_repeat
`define BIT_RUN        15
`define BIT_UNLOCK     13
`define BIT_ROLL       12
`define BIT_HALF       11
`define BIT_OE         10
`define BIT_AEN        15
`define BIT_CHIME      14
// unlock key values
`define KEY_FIRST      8'h55
`define KEY_SECOND     8'hAA
// implemented bits of each time digit byte
`define MASK_SEC       8'h7F
`define MASK_HR        8'h3F
`define MASK_WDAY      8'h07
`define MASK_DAY       8'h3F
`define MASK_MON       8'h1F
// reset values of day and month
`define RST_DAY        8'h01
`define RST_MON        8'h01
// source ticks per second is 2**15; ripple window before each rollover
`define ROLL_WIN_TICKS 15'h0020
`define ROLL_START     (15'h7FFF - `ROLL_WIN_TICKS + 15'h0001)
// calibration unit is 4 source pulses per minute: shift by 2
`define CAL_SHIFT      2
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// file: logic/rtc_pkg.sv
package rtc_pkg;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic [2:0]  awprot;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic [2:0]  arprot;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic [1:0]  src_meta, src_sync;
    logic        src_prev, fuse_meta, fuse_sync;
    logic [14:0] presc;
    logic [10:0] adj;
    logic        sec_pulse, half_pulse;
    logic [7:0]  sec, min, hr, wday, day, mon, yr;
    logic [7:0]  asec, amin, ahr, awday, aday, amon;
    logic        run_en, unlock, oe;
    logic [1:0]  tptr, sel, aptr;
    logic [7:0]  cal, repeat_cnt;
    logic        alarm_en, chime, alarm_tgl;
    logic [3:0]  interval;
    key_state_t  key;
    logic        pin_out, pin_oe_n;
    logic        aw_held, w_held, bvalid, rvalid;
    logic [7:0]  awaddr;
    logic [15:0] wdata, rdata;
    logic [1:0]  wstrb, bresp, rresp;
  } state_t;
endpackage

// file: verification/rtc_calendar_alarm_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_calendar_alarm_control_tb;
  localparam logic [1:0] OK = `RESP_OKAY;
  localparam logic [1:0] ER = `RESP_SLVERR;
  logic              aclk = 1'b0;
  logic              aresetn;
  rtc_pkg::axi_req_t req;
  rtc_pkg::axi_rsp_t rsp;
  logic              pin_out;
  logic              pin_oe_n;
  logic              rc_osc;
  logic              fuse;
  logic              p0;
  int                err_count;
  int                cmp_count;

  // the RC source toggles every clock; the crystal source stays idle
  rtc_calendar_alarm_control dut_u (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .s_axi_req             (req),
    .s_axi_rsp             (rsp),
    .secondary_crystal_osc (1'b0),
    .low_power_rc_osc      (rc_osc),
    .clock_source_fuse     (fuse),
    .clock_pin_out         (pin_out),
    .clock_pin_oe_n        (pin_oe_n)
  );

  // 4 ns clock
  always #2 aclk = ~aclk;

  // RC source at half the bus clock, quiet in reset
  always @(posedge aclk) rc_osc <= aresetn ? ~rc_osc : 1'b0;

  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // value comparison
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  // response code comparison
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  // write with address and data offered together, bready held high;
  // handshakes are sampled at the falling edge, where they have settled
  task automatic wrc(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    int         n;
    logic       aw_ok;
    logic       w_ok;
    logic       got;
    logic [1:0] resp;
    n = 0;
    got = 1'b0;
    resp = 2'h0;
    req.awaddr <= {24'h0, a};
    req.wdata <= {16'h0, d};
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_ok = req.awvalid && rsp.awready;
      w_ok = req.wvalid && rsp.wready;
      got = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge aclk);
      n++;
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
    end while (!got && n < 50);
    if (!got) begin
      err_count++;
      $display("wrong value at %0t: no write response", $time);
    end
    chk_resp(resp, er);
  endtask

  // read and compare, rready held high; data taken where rvalid stands
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int          n;
    logic        ar_ok;
    logic        got;
    logic [31:0] data;
    logic [1:0]  resp;
    n = 0;
    got = 1'b0;
    data = 32'h0;
    resp = 2'h0;
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar_ok = req.arvalid && rsp.arready;
      got = rsp.rvalid;
      data = rsp.rdata;
      resp = rsp.rresp;
      @(posedge aclk);
      n++;
      if (ar_ok) req.arvalid <= 1'b0;
    end while (!got && n < 50);
    if (!got) begin
      err_count++;
      $display("wrong value at %0t: no read response", $time);
    end
    chk_val(data, ed);
    chk_resp(resp, er);
  endtask

  // key pair that arms the next control write
  task automatic unlock();
    wrc(`OFS_KEY, {8'h0, `KEY_FIRST}, 4'h1, OK);
    wrc(`OFS_KEY, {8'h0, `KEY_SECOND}, 4'h1, OK);
  endtask

  // hang guard, above the roughly 66,500 cycles the tests need
  initial begin
    #320000;
    err_count++;
    stop_test();
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    fuse = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(`OFS_CFG, 32'h0, OK);
    rdc(`OFS_PAD, 32'h0, OK);
    rdc(`OFS_ALARM, 32'h0, OK);
    rdc(`OFS_KEY, 32'h0, OK);
    chk_val({31'h0, pin_oe_n}, 32'h1);
    rdc(8'h1C, 32'h0, ER);
    wrc(8'h1C, 16'hFFFF, 4'h3, ER);
    // writes refused while locked
    wrc(`OFS_YEAR, 16'h0042, 4'h3, OK);
    rdc(`OFS_YEAR, 32'h0, OK);
    wrc(`OFS_CFG, 16'hA000, 4'h3, OK);
    rdc(`OFS_CFG, 32'h0, OK);
    unlock();
    wrc(`OFS_CFG, 16'hA300, 4'h3, OK);
    rdc(`OFS_CFG, 32'h2300, OK);
    wrc(`OFS_YEAR, 16'hFF99, 4'h3, OK);
    rdc(`OFS_YEAR, 32'h99, OK);
    // time window walk from pointer 11 down
    rdc(`OFS_TIME_WIN, 32'h0099, OK);
    rdc(`OFS_TIME_WIN, 32'h0101, OK);
    wrc(`OFS_TIME_WIN, 16'h0523, 4'h3, OK);
    rdc(`OFS_CFG, 32'h2000, OK);
    rdc(`OFS_TIME_WIN, 32'h0, OK);
    rdc(`OFS_CFG, 32'h2000, OK);
    wrc(`OFS_CFG, 16'h0100, 4'h3, OK);
    wrc(`OFS_TIME_WIN, 16'h0611, 4'h3, OK);
    wrc(`OFS_CFG, 16'h0100, 4'h3, OK);
    rdc(`OFS_TIME_WIN, 32'h0523, OK);
    // run bit and pin enable
    unlock();
    wrc(`OFS_CFG, 16'h2400, 4'h3, OK);
    wrc(`OFS_CFG, 16'hA400, 4'h3, OK);
    rdc(`OFS_CFG, 32'hA400, OK);
    chk_val({31'h0, pin_oe_n}, 32'h0);
    wrc(`OFS_PAD, 16'hFFFF, 4'h3, OK);
    rdc(`OFS_PAD, 32'h6, OK);
    repeat (2) @(posedge aclk);
    chk_val({31'h0, pin_out}, 32'h0);
    // alarm window walk
    wrc(`OFS_ALARM, 16'h4300, 4'h3, OK);
    wrc(`OFS_ALARM_WIN, 16'h1200, 4'h2, OK);
    rdc(`OFS_ALARM, 32'h4200, OK);
    rdc(`OFS_ALARM_WIN, 32'h0, OK);
    rdc(`OFS_ALARM, 32'h4100, OK);
    wrc(`OFS_ALARM_WIN, 16'h0312, 4'h3, OK);
    wrc(`OFS_ALARM, 16'h4100, 4'h3, OK);
    rdc(`OFS_ALARM_WIN, 32'h0312, OK);
    // calendar running: one tick every second clock, phase restarted here
    wrc(`OFS_TIME_WIN, 16'h0000, 4'h1, OK);
    wrc(`OFS_PAD, 16'h0000, 4'h1, OK);
    wrc(`OFS_ALARM, 16'h8000, 4'h3, OK);
    repeat (33000) @(posedge aclk);
    rdc(`OFS_CFG, 32'hAC00, OK);
    rdc(`OFS_ALARM, 32'h0, OK);
    chk_val({31'h0, pin_out}, 32'h1);
    wrc(`OFS_ALARM, 16'hC000, 4'h3, OK);
    repeat (33000) @(posedge aclk);
    rdc(`OFS_CFG, 32'hA400, OK);
    rdc(`OFS_ALARM, 32'hC0FF, OK);
    rdc(`OFS_TIME_WIN, 32'h0001, OK);
    chk_val({31'h0, pin_out}, 32'h0);
    // raw source on the pin, then the fuse picks the idle crystal
    wrc(`OFS_PAD, 16'h0004, 4'h1, OK);
    @(negedge aclk);
    p0 = pin_out;
    @(negedge aclk);
    chk_val({31'h0, pin_out ^ p0}, 32'h1);
    @(posedge aclk);
    fuse <= 1'b1;
    repeat (6) @(negedge aclk);
    chk_val({31'h0, pin_out}, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
